// ===== design/rsq_pkg.sv
package rsq_pkg;
  // =========================================================
  // Widths
  localparam int BYTE_W = 8;
  localparam int REPLY_W = 16;
  localparam int CODE_W = 8;
  localparam int IN_W = 9;
  localparam int IN_MARK_BIT = 8;
  localparam int BIG_CNT_W = 8;
  localparam int ERR_CNT_W = 5;
  // =========================================================
  // Event status layout, shared by the register and its enable
  localparam int EV_PON = 7;
  localparam int EV_CME = 5;
  localparam int EV_EXE = 4;
  localparam int EV_DDE = 3;
  localparam int EV_QYE = 2;
  localparam int EV_OPC = 0;
  localparam logic [7:0] EV_IMPL_MASK = 8'hbd;
  localparam logic [7:0] EV_RESET = 8'h00;
  // =========================================================
  // Serial poll status byte layout
  localparam int SB_RQS = 6;
  localparam int SB_ESB = 5;
  localparam int SB_MAV = 4;
  localparam int SB_EAV = 3;
  localparam logic [7:0] SRE_IMPL_MASK = 8'h38;
  localparam logic [7:0] SRE_RESET = 8'h00;
  // =========================================================
  // Queue depths and flow thresholds
  localparam int INBUF_DEPTH = 250;
  localparam int OUTQ_DEPTH = 250;
  localparam int ERRQ_DEPTH = 16;
  localparam int ERRQ_KEEP = 15;
  localparam int XOFF_PCT = 80;
  localparam int XON_PCT = 40;
  localparam int XOFF_LEVEL = INBUF_DEPTH * XOFF_PCT / 100;
  localparam int XON_LEVEL = INBUF_DEPTH * XON_PCT / 100;
  localparam logic [BIG_CNT_W-1:0] IN_FULL = BIG_CNT_W'(INBUF_DEPTH);
  localparam logic [BIG_CNT_W-1:0] OUT_FULL = BIG_CNT_W'(OUTQ_DEPTH);
  localparam logic [BIG_CNT_W-1:0] XOFF_CNT = BIG_CNT_W'(XOFF_LEVEL);
  localparam logic [BIG_CNT_W-1:0] XON_CNT = BIG_CNT_W'(XON_LEVEL);
  localparam logic [ERR_CNT_W-1:0] ERRQ_KEEP_CNT = ERR_CNT_W'(ERRQ_KEEP);
  localparam logic [ERR_CNT_W-1:0] ERRQ_FULL_CNT = ERR_CNT_W'(ERRQ_DEPTH);
  localparam logic [CODE_W-1:0] ERR_OVERFLOW_CODE = 8'h01;
  localparam logic [CODE_W-1:0] ERR_EMPTY_CODE = 8'h00;
  // =========================================================
  // Serial flow state
  typedef enum logic {
    FLOW_ON = 1'b0,
    FLOW_OFF = 1'b1
  } rsq_flow_e;
endpackage

// ===== design/rsq_status_queues.sv
`timescale 1ns/10ps

// =========================================================
// Parameterised FIFO
module rsq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clear_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [CNT_W-1:0] count_o
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] cnt_q;
  wire push = in_valid_i & in_ready_o;
  wire pop = out_valid_o & out_ready_i;

  function automatic logic [PTR_W-1:0] bump(logic [PTR_W-1:0] p);
    return (p == LAST) ? '0 : p + PTR_W'(1);
  endfunction

  assign in_ready_o = (cnt_q != FULL);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rd_ptr_q];
  assign count_o = cnt_q;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || clear_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_ptr_q <= bump(wr_ptr_q);
      if (pop) rd_ptr_q <= bump(rd_ptr_q);
      cnt_q <= cnt_q + CNT_W'(push) - CNT_W'(pop);
    end
  end
endmodule

// =========================================================
// Status registers and remote queues
module rsq_status_queues
  import rsq_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic cmd_err_i,
  input wire logic exe_err_i,
  input wire logic dev_err_i,
  input wire logic [CODE_W-1:0] err_code_i,
  input wire logic opc_cmd_i,
  input wire logic ops_idle_i,
  input wire logic esr_read_i,
  input wire logic ese_read_i,
  input wire logic ese_write_i,
  input wire logic [REPLY_W-1:0] ese_wdata_i,
  input wire logic sre_write_i,
  input wire logic [BYTE_W-1:0] sre_wdata_i,
  input wire logic stb_read_i,
  input wire logic serial_poll_i,
  input wire logic fault_read_i,
  input wire logic cls_i,
  input wire logic rst_cmd_i,
  input wire logic dev_clear_i,
  output logic reply_valid_o,
  output logic [REPLY_W-1:0] reply_data_o,
  output logic srq_o,
  input wire logic resp_valid_i,
  input wire logic [BYTE_W-1:0] resp_data_i,
  output logic resp_ready_o,
  input wire logic talk_req_i,
  output logic talk_valid_o,
  output logic [BYTE_W-1:0] talk_data_o,
  input wire logic rx_valid_i,
  input wire logic [BYTE_W-1:0] rx_data_i,
  input wire logic rx_eoi_i,
  output logic nrfd_o,
  output logic cmd_valid_o,
  output logic [BYTE_W-1:0] cmd_data_o,
  output logic cmd_eoi_o,
  input wire logic cmd_ready_i,
  output logic xoff_send_o,
  output logic xon_send_o
);
  // =========================================================
  // Shared helpers
  function automatic logic [BIG_CNT_W-1:0] cnt_next(
      logic [BIG_CNT_W-1:0] c, logic push, logic pop);
    return c + BIG_CNT_W'(push) - BIG_CNT_W'(pop);
  endfunction

  function automatic logic [7:0] stb_byte(logic b6, logic event_summary_bit, logic message_available_bit,
                                          logic eav);
    logic [7:0] s;
    s = 8'h00;
    s[SB_RQS] = b6;
    s[SB_ESB] = event_summary_bit;
    s[SB_MAV] = message_available_bit;
    s[SB_EAV] = eav;
    return s;
  endfunction

  // =========================================================
  // Event status and enable
  logic [7:0] esr_q;
  logic [7:0] ese_q;
  logic [7:0] sre_q;
  logic pon_pend_q;
  logic opc_pend_q;
  logic qry_evt;
  logic [7:0] esr_set;
  wire clr_esr = esr_read_i | cls_i | rst_cmd_i | dev_clear_i;
  wire opc_fire = opc_pend_q & ops_idle_i;

  always_comb begin
    esr_set = 8'h00;
    esr_set[EV_PON] = pon_pend_q;
    esr_set[EV_CME] = cmd_err_i & ese_q[EV_CME];
    esr_set[EV_EXE] = exe_err_i;
    esr_set[EV_DDE] = dev_err_i;
    esr_set[EV_QYE] = qry_evt;
    esr_set[EV_OPC] = opc_fire;
  end

  // Set wins over any clear in the same cycle
  wire [7:0] esr_d = ((esr_q & ~{8{clr_esr}}) | esr_set)
                     & EV_IMPL_MASK;
  wire opc_pend_d = (opc_pend_q | opc_cmd_i) & ~opc_fire
                    & ~cls_i & ~rst_cmd_i;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      esr_q <= EV_RESET;
      ese_q <= EV_RESET;
      sre_q <= SRE_RESET;
      pon_pend_q <= 1'b1;
      opc_pend_q <= 1'b0;
    end else begin
      esr_q <= esr_d;
      if (ese_write_i) ese_q <= ese_wdata_i[7:0] & EV_IMPL_MASK;
      if (sre_write_i) sre_q <= sre_wdata_i & SRE_IMPL_MASK;
      pon_pend_q <= 1'b0;
      opc_pend_q <= opc_pend_d;
    end
  end

  // =========================================================
  // Output queue
  logic [BIG_CNT_W-1:0] outq_cnt;
  logic [BYTE_W-1:0] outq_head;
  logic outq_ready_q;
  logic talk_valid_q;
  logic [BYTE_W-1:0] talk_data_q;
  wire outq_push = resp_valid_i & outq_ready_q;
  wire outq_nonempty = (outq_cnt != '0);
  wire outq_pop = talk_req_i & outq_nonempty;
  wire [BIG_CNT_W-1:0] outq_nxt = cnt_next(outq_cnt, outq_push, outq_pop);
  // Either the host talked to an empty queue or left it to overflow
  assign qry_evt = (talk_req_i & ~outq_nonempty)
                   | (resp_valid_i & ~outq_ready_q);

  rsq_fifo #(.WIDTH(BYTE_W), .DEPTH(OUTQ_DEPTH), .CNT_W(BIG_CNT_W)) u_outq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(1'b0),
    .in_valid_i(outq_push),
    .in_ready_o(),
    .in_data_i(resp_data_i),
    .out_valid_o(),
    .out_ready_i(outq_pop),
    .out_data_o(outq_head),
    .count_o(outq_cnt)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      outq_ready_q <= 1'b1;
      talk_valid_q <= 1'b0;
      talk_data_q <= 8'h00;
    end else begin
      outq_ready_q <= (outq_nxt != OUT_FULL);
      talk_valid_q <= outq_pop;
      if (outq_pop) talk_data_q <= outq_head;
    end
  end

  // =========================================================
  // Error queue, first errors kept
  logic [ERR_CNT_W-1:0] errq_cnt;
  logic [CODE_W-1:0] errq_head;
  wire err_any = cmd_err_i | exe_err_i | dev_err_i;
  wire errq_room = (errq_cnt != ERRQ_FULL_CNT);
  wire [CODE_W-1:0] errq_in = (errq_cnt == ERRQ_KEEP_CNT) ?
                              ERR_OVERFLOW_CODE : err_code_i;
  wire errq_pop = fault_read_i & (errq_cnt != '0);

  rsq_fifo #(.WIDTH(CODE_W), .DEPTH(ERRQ_DEPTH), .CNT_W(ERR_CNT_W)) u_errq (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(cls_i),
    .in_valid_i(err_any & errq_room),
    .in_ready_o(),
    .in_data_i(errq_in),
    .out_valid_o(),
    .out_ready_i(errq_pop),
    .out_data_o(errq_head),
    .count_o(errq_cnt)
  );

  // =========================================================
  // Status byte and service request
  logic rqs_q;
  logic [7:0] src_prev_q;
  wire event_summary_bit = |(esr_q & ese_q);
  wire eav = (errq_cnt != '0);
  wire [7:0] src_en = stb_byte(1'b0, event_summary_bit, outq_nonempty, eav)
                      & sre_q;
  wire mss = |src_en;
  wire rqs_rise = |(src_en & ~src_prev_q);
  wire rqs_d = rqs_rise | (rqs_q & mss & ~serial_poll_i & ~cls_i);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      rqs_q <= 1'b0;
      src_prev_q <= 8'h00;
    end else begin
      rqs_q <= rqs_d;
      src_prev_q <= src_en;
    end
  end

  // =========================================================
  // Reply selection
  logic reply_valid_q;
  logic [REPLY_W-1:0] reply_data_q;
  wire [7:0] poll_byte = stb_byte(rqs_q, event_summary_bit, outq_nonempty, eav);
  wire [7:0] stbq_byte = stb_byte(mss, event_summary_bit, outq_nonempty, eav);
  wire [CODE_W-1:0] fault_code = errq_pop ? errq_head : ERR_EMPTY_CODE;
  wire reply_any = esr_read_i | ese_read_i | stb_read_i | serial_poll_i
                   | fault_read_i;
  wire [REPLY_W-1:0] reply_sel =
      esr_read_i    ? {8'h00, esr_q} :
      ese_read_i    ? {8'h00, ese_q} :
      serial_poll_i ? {8'h00, poll_byte} :
      stb_read_i    ? {8'h00, stbq_byte} :
                      {8'h00, fault_code};

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      reply_valid_q <= 1'b0;
      reply_data_q <= 16'h0000;
    end else begin
      reply_valid_q <= reply_any;
      if (reply_any) reply_data_q <= reply_sel;
    end
  end

  // =========================================================
  // Input buffer with handshake hold-off and serial flow control
  logic nrfd_q;
  logic eoi_pend_q;
  logic [BIG_CNT_W-1:0] in_cnt;
  logic in_ready;
  logic in_out_valid;
  logic [IN_W-1:0] in_head;
  logic cmd_valid_q;
  logic [BYTE_W-1:0] cmd_data_q;
  logic cmd_eoi_q;
  rsq_flow_e flow_q;
  logic xoff_q;
  logic xon_q;
  wire rx_take = rx_valid_i & ~nrfd_q & ~eoi_pend_q;
  wire [IN_W-1:0] in_word = eoi_pend_q ? {1'b1, 8'h00}
                                       : {1'b0, rx_data_i};
  wire in_push = (rx_take | eoi_pend_q) & in_ready;
  wire in_pop = in_out_valid & (~cmd_valid_q | cmd_ready_i);
  wire [BIG_CNT_W-1:0] in_nxt = cnt_next(in_cnt, in_push, in_pop);
  wire eoi_pend_d = (eoi_pend_q & ~in_push)
                    | (rx_take & rx_eoi_i);

  rsq_fifo #(.WIDTH(IN_W), .DEPTH(INBUF_DEPTH), .CNT_W(BIG_CNT_W)) u_inbuf (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(dev_clear_i),
    .in_valid_i(rx_take | eoi_pend_q),
    .in_ready_o(in_ready),
    .in_data_i(in_word),
    .out_valid_o(in_out_valid),
    .out_ready_i(in_pop),
    .out_data_o(in_head),
    .count_o(in_cnt)
  );

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || dev_clear_i) begin
      nrfd_q <= 1'b0;
      eoi_pend_q <= 1'b0;
      cmd_valid_q <= 1'b0;
      cmd_data_q <= 8'h00;
      cmd_eoi_q <= 1'b0;
    end else begin
      // Stays asserted on a full buffer until a drain frees a slot, and while an end marker waits to be pushed
      nrfd_q <= (in_nxt == IN_FULL) | eoi_pend_d;
      eoi_pend_q <= eoi_pend_d;
      if (in_pop) begin
        cmd_valid_q <= 1'b1;
        cmd_data_q <= in_head[BYTE_W-1:0];
        cmd_eoi_q <= in_head[IN_MARK_BIT];
      end else if (cmd_ready_i) begin
        cmd_valid_q <= 1'b0;
      end
    end
  end

  wire go_off = (flow_q == FLOW_ON) & (in_nxt >= XOFF_CNT);
  wire go_on = (flow_q == FLOW_OFF) & (in_nxt < XON_CNT);

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      flow_q <= FLOW_ON;
      xoff_q <= 1'b0;
      xon_q <= 1'b0;
    end else begin
      case (flow_q)
        FLOW_ON: if (go_off) flow_q <= FLOW_OFF;
        FLOW_OFF: if (go_on) flow_q <= FLOW_ON;
        default: flow_q <= FLOW_ON;
      endcase
      xoff_q <= go_off;
      xon_q <= go_on;
    end
  end

  assign reply_valid_o = reply_valid_q;
  assign reply_data_o = reply_data_q;
  assign srq_o = rqs_q;
  assign resp_ready_o = outq_ready_q;
  assign talk_valid_o = talk_valid_q;
  assign talk_data_o = talk_data_q;
  assign nrfd_o = nrfd_q;
  assign cmd_valid_o = cmd_valid_q;
  assign cmd_data_o = cmd_data_q;
  assign cmd_eoi_o = cmd_eoi_q;
  assign xoff_send_o = xoff_q;
  assign xon_send_o = xon_q;

  // =========================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  esr_reply_a: assert property (esr_read_i |=> reply_valid_o
      && reply_data_o == {8'h00, $past(esr_q)})
    else $error("event register reply wrong");
  esr_read_clr_a: assert property (
      esr_read_i && esr_set == 8'h00 |=> esr_q == 8'h00)
    else $error("event register not cleared by read");
  cme_set_a: assert property (
      cmd_err_i && ese_q[EV_CME] |=> esr_q[EV_CME])
    else $error("command error bit not set");
  esr_hold_a: assert property (!clr_esr |=>
      (esr_q & $past(esr_q)) == $past(esr_q))
    else $error("event bit lost without clear");
  ese_keep_a: assert property (
      ese_read_i && !ese_write_i |=> $stable(ese_q))
    else $error("enable changed by read");
  esb_poll_a: assert property (
      serial_poll_i && (esr_q & ese_q) != 8'h00 |=> reply_data_o[SB_ESB])
    else $error("summary bit missing");
  mav_poll_a: assert property (serial_poll_i |=>
      reply_data_o[SB_MAV] == ($past(outq_cnt) != '0))
    else $error("message available wrong");
  errq_ovf_a: assert property (
      err_any && errq_cnt == ERRQ_KEEP_CNT && !fault_read_i && !cls_i
      |=> errq_cnt == ERRQ_FULL_CNT ##1 1'b1)
    else $error("overflow entry not stored");
  fault_empty_a: assert property (
      fault_read_i && errq_cnt == '0 |=> reply_data_o == 16'h0000)
    else $error("empty error queue read not zero");
  nrfd_full_a: assert property (in_cnt == IN_FULL |-> nrfd_o)
    else $error("not ready missing on full buffer");
  srq_rise_a: assert property (rqs_rise |=> srq_o)
    else $error("service request not raised");
  cls_clear_a: assert property (
      cls_i && esr_set == 8'h00 && !err_any |=> esr_q == 8'h00
      && errq_cnt == '0 && !srq_o)
    else $error("clear status incomplete");
  xoff_a: assert property (
      go_off |=> xoff_send_o ##1 !xoff_send_o)
    else $error("flow off not sent");

  errq_ovf_c: cover property (errq_cnt == ERRQ_FULL_CNT);
  nrfd_c: cover property (nrfd_o ##1 !nrfd_o);
  xon_c: cover property (xoff_send_o ##[1:1000] xon_send_o);
  srq_c: cover property (srq_o ##1 serial_poll_i);
endmodule

// ===== verif/rsq_host.sv
`timescale 1ns/10ps
// ==========================================================
// Host controller model on the parallel input link
module rsq_host (
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic ser_i,
  input wire logic eoi_i,
  input wire logic nrfd_i,
  input wire logic xoff_i,
  input wire logic xon_i,
  output logic rx_valid_o,
  output logic [7:0] rx_data_o,
  output logic rx_eoi_o
);
  logic paused_q;
  initial begin
    rx_valid_o = 1'b0;
    rx_data_o = 8'h5a;
    rx_eoi_o = 1'b0;
    paused_q = 1'b0;
  end
  always @(posedge clk_i) begin
    if (xoff_i) paused_q <= 1'b1;
    if (xon_i) paused_q <= 1'b0;
    // A byte stays offered until an edge with not-ready low takes it
    if (rx_valid_o && !nrfd_i) begin
      rx_valid_o <= 1'b0;
      rx_data_o <= ~rx_data_o;
      rx_eoi_o <= 1'b0;
    end else if (!rx_valid_o && go_i && !(ser_i && paused_q)) begin
      rx_valid_o <= 1'b1;
      rx_data_o <= rx_data_o * 8'h05 + 8'h3b;
      rx_eoi_o <= eoi_i & rx_data_o[0];
    end
  end
endmodule

// ===== verif/testbench.sv
`timescale 1ns/10ps
module testbench
  import rsq_pkg::*;
;
  logic clk_i, reset_n_i, idle, go, ser, eoi, crdy;
  logic [2:0] er;
  logic [4:0] rq;
  logic [7:0] pl;
  logic [CODE_W-1:0] code;
  logic [REPLY_W-1:0] ese_d;
  logic [BYTE_W-1:0] sre_d, rsp_d;
  wire logic rv, srq, rrdy, tv, nrfd, cv, ceoi, xoff, xon, rxv, rxe;
  wire logic [REPLY_W-1:0] rdata;
  wire logic [BYTE_W-1:0] td, cd, rxd;
  int fails, compares, seed, i, k;
  int words = 0;
  logic xoff_seen = 1'b0;
  logic xon_seen = 1'b0;
  logic [8:0] exp_q[$];
  logic [7:0] codes[17];

  rsq_status_queues dut (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .cmd_err_i(er[0]), .exe_err_i(er[1]), .dev_err_i(er[2]),
    .err_code_i(code), .opc_cmd_i(pl[3]), .ops_idle_i(idle),
    .esr_read_i(rq[0]), .ese_read_i(rq[1]), .serial_poll_i(rq[2]),
    .stb_read_i(rq[3]), .fault_read_i(rq[4]),
    .ese_write_i(pl[4]), .ese_wdata_i(ese_d),
    .sre_write_i(pl[5]), .sre_wdata_i(sre_d),
    .cls_i(pl[0]), .rst_cmd_i(pl[1]), .dev_clear_i(pl[2]),
    .reply_valid_o(rv), .reply_data_o(rdata), .srq_o(srq),
    .resp_valid_i(pl[6]), .resp_data_i(rsp_d), .resp_ready_o(rrdy),
    .talk_req_i(pl[7]), .talk_valid_o(tv), .talk_data_o(td),
    .rx_valid_i(rxv), .rx_data_i(rxd), .rx_eoi_i(rxe),
    .nrfd_o(nrfd), .cmd_valid_o(cv), .cmd_data_o(cd),
    .cmd_eoi_o(ceoi), .cmd_ready_i(crdy),
    .xoff_send_o(xoff), .xon_send_o(xon)
  );

  rsq_host host (
    .clk_i(clk_i), .go_i(go), .ser_i(ser), .eoi_i(eoi),
    .nrfd_i(nrfd), .xoff_i(xoff), .xon_i(xon),
    .rx_valid_o(rxv), .rx_data_o(rxd), .rx_eoi_o(rxe)
  );

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // ==========================================================
  // Shared tasks
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("[FAIL] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  // Status byte expected from the published bit positions
  function automatic logic [15:0] stb_exp(input logic b6, input logic event_summary_bit,
      input logic message_available_bit, input logic eav);
    logic [15:0] s;
    s = 16'h0000;
    s[SB_RQS] = b6;
    s[SB_ESB] = event_summary_bit;
    s[SB_MAV] = message_available_bit;
    s[SB_EAV] = eav;
    return s;
  endfunction

  task automatic rd(input int n, input logic [15:0] e);
    @(posedge clk_i) rq <= 5'h1 << n;
    @(posedge clk_i) rq <= 5'h0;
    #1 chk({15'h0, rv}, 16'h1);
    chk(rdata, e);
  endtask

  task automatic pul(input int n);
    @(posedge clk_i) pl <= 8'h1 << n;
    @(posedge clk_i) pl <= 8'h0;
  endtask

  task automatic err(input int n, input logic [7:0] c);
    @(posedge clk_i) er <= 3'h1 << n;
    code <= c;
    @(posedge clk_i) er <= 3'h0;
  endtask

  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Input link monitor: every word taken must drain in order
  always @(posedge clk_i) begin
    if (xoff) xoff_seen <= 1'b1;
    if (xon) xon_seen <= 1'b1;
    if (rxv && !nrfd && reset_n_i) begin
      exp_q.push_back({1'b0, rxd});
      if (rxe) exp_q.push_back(9'h100);
      words <= words + (rxe ? 2 : 1);
    end
    if (cv && crdy) begin
      chk({7'h0, ceoi, cd}, {7'h0, exp_q.pop_front()});
    end
  end

  initial begin
    #(40 * 30000);
    fails++;
    end_sim();
  end

  // ==========================================================
  // Main sequence
  initial begin
    seed = 32'hb68e5b83;
    {er, rq, pl, code, idle, ese_d, sre_d, rsp_d, go, ser, eoi, crdy} = '0;
    fails = 0;
    compares = 0;
    for (i = 0; i < 17; i++) codes[i] = 8'($random(seed));
    reset_n_i = 1'b0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    rd(0, 16'h0080);
    chk({15'h0, rrdy}, 16'h0001);
    rd(0, 16'h0000);
    // Command error with its enable still clear: queued, bit stays low
    err(0, codes[16]);
    rd(0, 16'h0000);
    rd(4, {8'h0, codes[16]});
    @(posedge clk_i) ese_d <= 16'hffff;
    pul(4);
    rd(1, 16'h00bd);
    rd(1, 16'h00bd);
    err(0, codes[0]);
    err(2, codes[1]);
    @(posedge clk_i) idle <= 1'b1;
    pul(3);
    repeat (3) @(posedge clk_i);
    rd(0, 16'h0029);
    rd(4, {8'h0, codes[0]});
    rd(4, {8'h0, codes[1]});
    rd(4, 16'h0000);
    for (i = 0; i < 17; i++) err(1, codes[i]);
    #1 chk({15'h0, srq}, 16'h0);
    for (i = 0; i < 15; i++) rd(4, {8'h0, codes[i]});
    rd(4, {8'h0, ERR_OVERFLOW_CODE});
    rd(4, 16'h0000);
    for (k = 0; k < 3; k++) begin
      err(1, 8'h10);
      pul(k);
      rd(0, 16'h0000);
    end
    pul(0);
    rd(4, 16'h0000);
    @(posedge clk_i) sre_d <= 8'hff;
    pul(5);
    err(1, 8'h20);
    repeat (2) @(posedge clk_i);
    #1 chk({15'h0, srq}, 16'h1);
    rd(2, stb_exp(1'b1, 1'b1, 1'b0, 1'b1));
    chk({15'h0, srq}, 16'h0);
    rd(3, stb_exp(1'b1, 1'b1, 1'b0, 1'b1));
    @(posedge clk_i) sre_d <= 8'h10;
    pul(5);
    rd(3, stb_exp(1'b0, 1'b1, 1'b0, 1'b1));
    pul(0);
    for (i = 0; i < 3; i++) begin
      @(posedge clk_i) rsp_d <= codes[i];
      pul(6);
    end
    rd(3, stb_exp(1'b1, 1'b0, 1'b1, 1'b0));
    chk({15'h0, srq}, 16'h1);
    for (i = 0; i < 3; i++) begin
      pul(7);
      #1 chk({15'h0, tv}, 16'h1);
      chk({8'h0, td}, {8'h0, codes[i]});
    end
    pul(7);
    #1 chk({15'h0, tv}, 16'h0);
    rd(0, 16'h0004);
    rd(3, 16'h0000);
    // Output queue to its limit; one more push is refused and flagged
    for (i = 0; i < 250; i++) begin
      @(posedge clk_i) rsp_d <= 8'(i);
      pul(6);
    end
    #1 chk({15'h0, rrdy}, 16'h0000);
    pul(6);
    rd(0, 16'h0004);
    for (i = 0; i < 250; i++) begin
      pul(7);
      #1 chk({8'h0, td}, {8'h0, 8'(i)});
    end
    chk({15'h0, rrdy}, 16'h0001);
    // Fill with the drain stalled, then drain with random stalls
    @(posedge clk_i) go <= 1'b1;
    for (i = 0; i < 900 && words < 250; i++) @(posedge clk_i);
    repeat (20) @(posedge clk_i);
    #1 chk({15'h0, nrfd}, 16'h1);
    // Buffer full plus the one word parked in the drain stage
    chk(16'(words), 16'h00fb);
    chk({15'h0, xoff_seen}, 16'h1);
    @(posedge clk_i) begin
      ser <= 1'b1;
      eoi <= 1'b1;
    end
    for (i = 0; i < 4000 && (exp_q.size() > 0 || i < 1200); i++) begin
      @(posedge clk_i) crdy <= 1'($random(seed));
      if (i == 800) go <= 1'b0;
    end
    chk({15'h0, (exp_q.size() == 0)}, 16'h1);
    chk({15'h0, xon_seen}, 16'h1);
    end_sim();
  end
endmodule
